// [logic/reset_hold_timer.sv]
`timescale 1ns/10ps
`include "reset_mode_map.svh"

// counts down a hold time once started; done is a level
module reset_hold_timer #(
    parameter int WIDTH = 32
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic                  done
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign done = (count == '0) && !load;

    chk_timer_counts_down :
    assert property (@(posedge clock) disable iff (!arst_n)
        (!load && count != '0) |=> count == $past(count) - 1'b1)
    else $error("hold timer failed to count down");
endmodule : reset_hold_timer

// [logic/reset_mode_control.sv]
`timescale 1ns/10ps
`include "reset_mode_map.svh"

// Behaviour
// - reset from power-on, glitch or soft command
// - mode starts sensitive, command sets normal
// - glitch causes reset only in sensitive mode
// - falling-supply threshold chosen by reset mode
// - any reset restores all registers, mode sensitive
// - soft reset restores registers like power-on, but holds only SOFT_HOLD_CYCLES
// - word FE00h decoded as reset request
// - bit one of pll command selects normal
// - commands ignored while reset active, 150ms after supply causes, SOFT_HOLD_CYCLES after soft
// - disable flag at bit one, clear permits glitches
module reset_mode_control #(
    parameter int POR_HOLD_CYCLES  = `POR_HOLD_CYCLES,
    parameter int SOFT_HOLD_CYCLES = `SOFT_HOLD_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        power_on_low,
    input  wire logic        glitch_detect,
    input  wire logic        below_low_level,
    input  wire logic        below_high_level,
    input  wire logic        cmd_valid,
    input  wire logic [15:0] cmd_word,
    output logic             cmd_accept,
    output logic             internal_reset,
    output logic             sensitive_reset_disable,
    output logic [1:0]       pll_bandwidth,
    output logic             glitch_detect_enable,
    output logic             threshold_select_high
);
    // ---------------------------------------------------------------
    // reset sources
    // ---------------------------------------------------------------
    reset_mode_pkg::seq_state_type state;
    reset_mode_pkg::seq_state_type next_state;
    logic        soft_reset_cmd;
    logic        pll_cmd;
    logic        supply_reset;
    logic        timer_load;
    logic [31:0] timer_value;
    logic        timer_done;
    logic        next_mode_disable;
    logic [1:0]  next_pll_bandwidth;

    localparam logic [1:0] BANDWIDTH_RESET =
        2'(`PLL_SETTING_RESET >> `PLL_BW_LSB);

    // reset refuses commands so soft word only decoded in run
    assign cmd_accept     = (state == reset_mode_pkg::RESET_RUN);
    assign soft_reset_cmd = cmd_valid && cmd_accept
                          && (cmd_word == `SOFT_RESET_WORD);
    assign pll_cmd        = cmd_valid && cmd_accept
                          && ((cmd_word & `PLL_MODE_MASK) == `PLL_MODE_CODE);

    // glitch gated by mode; threshold follows mode
    assign glitch_detect_enable  = !sensitive_reset_disable;
    assign threshold_select_high = !sensitive_reset_disable;
    assign supply_reset = power_on_low
        || (glitch_detect && glitch_detect_enable)
        || (sensitive_reset_disable ? below_low_level
                                    : below_high_level);

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    // a supply cause seen in hold reloads the full count, so a noisy
    // supply keeps the part in reset instead of letting it out half
    // settled; the price is a longer stay after every disturbance
    always_comb begin
        next_state  = state;
        timer_load  = 1'b0;
        timer_value = 32'(SOFT_HOLD_CYCLES);
        case (state)
            reset_mode_pkg::RESET_HOLD: begin
                if (supply_reset) begin
                    timer_load  = 1'b1;
                    timer_value = 32'(POR_HOLD_CYCLES);
                end else if (timer_done) begin
                    next_state = reset_mode_pkg::RESET_RUN;
                end
            end
            reset_mode_pkg::RESET_RUN: begin
                // soft reset takes the same path as power-on, but loads SOFT_HOLD_CYCLES instead of POR_HOLD_CYCLES
                if (supply_reset || soft_reset_cmd) begin
                    next_state  = reset_mode_pkg::RESET_HOLD;
                    timer_load  = 1'b1;
                    timer_value = supply_reset ? 32'(POR_HOLD_CYCLES)
                                               : 32'(SOFT_HOLD_CYCLES);
                end
            end
            default: begin
                next_state = reset_mode_pkg::RESET_HOLD;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= reset_mode_pkg::RESET_HOLD;
        end else begin
            state <= next_state;
        end
    end

    assign internal_reset = (state == reset_mode_pkg::RESET_HOLD);

    // one timer serves both hold lengths; 32 bits leave headroom
    // beyond the power-on count at the nominal clock
    reset_hold_timer #(
        .WIDTH(32)
    ) u_hold (
        .clock      (clock),
        .arst_n     (arst_n),
        .load       (timer_load),
        .load_value (timer_value),
        .done       (timer_done)
    );

    // ---------------------------------------------------------------
    // pll setting and reset mode register
    // ---------------------------------------------------------------
    // reset overrides commands, so a word slipping into the last hold
    // cycle cannot leave a stale mode behind
    always_comb begin
        next_mode_disable  = sensitive_reset_disable;
        next_pll_bandwidth = pll_bandwidth;
        if (internal_reset) begin
            next_mode_disable  = 1'b0;
            next_pll_bandwidth = 2'(`PLL_SETTING_RESET >> `PLL_BW_LSB);
        end else if (pll_cmd) begin
            next_mode_disable  = cmd_word[`MODE_DISABLE_BIT];
            next_pll_bandwidth = cmd_word[`PLL_BW_LSB +: 2];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sensitive_reset_disable <= 1'b0;
            pll_bandwidth           <= 2'(`PLL_SETTING_RESET >> `PLL_BW_LSB);
        end else begin
            sensitive_reset_disable <= next_mode_disable;
            pll_bandwidth           <= next_pll_bandwidth;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_soft_word_resets :
    assert property (@(posedge clock) disable iff (!arst_n)
        soft_reset_cmd |=> internal_reset)
    else $error("soft reset word did not reset");

    chk_reset_clears_mode :
    assert property (@(posedge clock) disable iff (!arst_n)
        internal_reset |=> !sensitive_reset_disable)
    else $error("mode not restored during reset");

    chk_refuse_in_reset :
    assert property (@(posedge clock) disable iff (!arst_n)
        internal_reset |-> !cmd_accept)
    else $error("command accepted during reset");

    chk_mode_set_normal :
    assert property (@(posedge clock) disable iff (!arst_n)
        (pll_cmd && cmd_word[1] && !supply_reset)
        |=> sensitive_reset_disable)
    else $error("mode bit did not select normal");

    chk_glitch_gated :
    assert property (@(posedge clock) disable iff (!arst_n)
        (cmd_accept && glitch_detect && !sensitive_reset_disable)
        |=> internal_reset)
    else $error("glitch in sensitive mode missed");

    chk_normal_ignores :
    assert property (@(posedge clock) disable iff (!arst_n)
        (cmd_accept && sensitive_reset_disable && !power_on_low
         && !below_low_level && !soft_reset_cmd)
        |=> !internal_reset)
    else $error("reset without cause in normal mode");

    chk_threshold_mode :
    assert property (@(posedge clock) disable iff (!arst_n)
        (cmd_accept && !sensitive_reset_disable && below_high_level)
        |=> internal_reset)
    else $error("high threshold ignored in sensitive mode");

    chk_power_on_resets :
    assert property (@(posedge clock) disable iff (!arst_n)
        power_on_low |=> internal_reset [*2])
    else $error("power-on did not hold reset");

    chk_refuse_decode :
    assert property (@(posedge clock) disable iff (!arst_n)
        (internal_reset && cmd_valid) |-> !(soft_reset_cmd || pll_cmd))
    else $error("command decoded during reset");

    chk_hold_not_early :
    assert property (@(posedge clock) disable iff (!arst_n)
        (internal_reset && !timer_done) |=> internal_reset)
    else $error("reset released before hold time");

    chk_soft_like_power :
    assert property (@(posedge clock) disable iff (!arst_n)
        soft_reset_cmd |=> ##1 (!sensitive_reset_disable
                                && pll_bandwidth == BANDWIDTH_RESET))
    else $error("soft reset left registers changed");

    chk_release_defaults :
    assert property (@(posedge clock) disable iff (!arst_n)
        $rose(cmd_accept)
        |-> (!sensitive_reset_disable && pll_bandwidth == BANDWIDTH_RESET))
    else $error("run entered without default registers");

    chk_normal_low_level :
    assert property (@(posedge clock) disable iff (!arst_n)
        (cmd_accept && sensitive_reset_disable && below_low_level)
        |=> internal_reset)
    else $error("low threshold ignored in normal mode");

    chk_bandwidth_load :
    assert property (@(posedge clock) disable iff (!arst_n)
        pll_cmd |=> pll_bandwidth == $past(cmd_word[`PLL_BW_LSB +: 2]))
    else $error("pll bandwidth not loaded");
endmodule : reset_mode_control

// [logic/reset_mode_map.svh]
`ifndef RESET_MODE_MAP_SVH
`define RESET_MODE_MAP_SVH

// command words, 16 bits
`define SOFT_RESET_WORD      16'hFE00
`define PLL_MODE_MASK        16'hFF3D
`define PLL_MODE_CODE        16'hD200
`define MODE_DISABLE_BIT     1
`define PLL_BW_LSB           6
`define PLL_SETTING_RESET    16'hD200

// timing
`define POR_HOLD_MS          150
`define CLOCK_KHZ            25000
`define POR_HOLD_CYCLES      (`POR_HOLD_MS * `CLOCK_KHZ)
`define SOFT_HOLD_CYCLES     4

`endif

// [logic/reset_mode_pkg.sv]
package reset_mode_pkg;
    typedef enum logic [1:0] {
        RESET_HOLD,
        RESET_RUN
    } seq_state_type;

    typedef enum logic {
        MODE_SENSITIVE,
        MODE_NORMAL
    } reset_mode_type;
endpackage : reset_mode_pkg

// [tb/host_model.sv]
`timescale 1ns/10ps

// ------------------------------------------------------------
// host side of the parallel 16-bit command word interface
// ------------------------------------------------------------
module host_model (
    input  wire logic        clock,
    input  wire logic        cmd_accept,
    output logic             cmd_valid,
    output logic [15:0]      cmd_word
);
    initial begin
        cmd_valid = 1'b0;
        cmd_word  = 16'h0000;
    end

    // push skips the wait, so a word can be sent into a reset on purpose
    task automatic send(input logic [15:0] word, input bit push);
        int n;
        n = 0;
        @(negedge clock);
        while (!push && cmd_accept !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        cmd_valid <= 1'b1;
        cmd_word  <= word;
        @(negedge clock);
        cmd_valid <= 1'b0;
        cmd_word  <= ~word;
    endtask : send
endmodule : host_model

// [tb/reset_mode_control_test.sv]
`timescale 1ns/10ps

module reset_mode_control_test;
    logic        clock = 1'b0, arst_n = 1'b0, power_on_low = 1'b0;
    logic        glitch_detect = 1'b0, below_low_level = 1'b0;
    logic        below_high_level = 1'b0, cmd_valid, cmd_accept;
    logic        internal_reset, sensitive_reset_disable;
    logic        glitch_detect_enable, threshold_select_high;
    logic [15:0] cmd_word;
    logic [1:0]  pll_bandwidth;
    int          n_fail = 0, n_compared = 0, m_mode = 0, m_bw = 0;

    always #20 clock = ~clock;

    reset_mode_control #(.POR_HOLD_CYCLES(20), .SOFT_HOLD_CYCLES(4)) DUT (
        .clock(clock), .arst_n(arst_n), .power_on_low(power_on_low),
        .glitch_detect(glitch_detect), .below_low_level(below_low_level),
        .below_high_level(below_high_level), .cmd_valid(cmd_valid),
        .cmd_word(cmd_word), .cmd_accept(cmd_accept),
        .internal_reset(internal_reset),
        .sensitive_reset_disable(sensitive_reset_disable),
        .pll_bandwidth(pll_bandwidth),
        .glitch_detect_enable(glitch_detect_enable),
        .threshold_select_high(threshold_select_high));

    host_model host (.clock(clock), .cmd_accept(cmd_accept),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word));

    task automatic chk(string what, logic [1:0] exp, logic [1:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk

    task automatic check_regs();
        chk("mode", 2'(m_mode), {1'b0, sensitive_reset_disable});
        chk("bandwidth", 2'(m_bw), pll_bandwidth);
        chk("glitch en", 2'(1 - m_mode),
            {1'b0, glitch_detect_enable});
        chk("threshold", 2'(1 - m_mode),
            {1'b0, threshold_select_high});
    endtask : check_regs

    task automatic wait_ready();
        int n;
        n = 0;
        while (cmd_accept !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        chk("ready", 2'b01, {1'b0, cmd_accept});
    endtask : wait_ready

    task automatic set_pll(logic [1:0] bw, logic normal);
        host.send(16'hD200 | {8'h00, bw, 4'h0, normal, 1'b0},
                  1'b0);
        m_bw = bw;
        m_mode = normal;
        @(negedge clock);
        check_regs();
    endtask : set_pll

    // 0 power-on, 1 glitch, 2 under high level, 3 under low level
    task automatic supply(int which, logic exp_reset);
        @(negedge clock);
        case (which)
            0: power_on_low = 1'b1;
            1: glitch_detect = 1'b1;
            2: below_high_level = 1'b1;
            default: {below_low_level, below_high_level} = 2'b11;
        endcase
        repeat (3) @(negedge clock);
        chk("reset", {1'b0, exp_reset}, {1'b0, internal_reset});
        {power_on_low, glitch_detect, below_low_level, below_high_level} = '0;
        if (exp_reset) begin
            m_mode = 0;
            m_bw = 0;
        end
        @(negedge clock);
        wait_ready();
        check_regs();
    endtask : supply

    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    initial begin
        #(40ns * 4000);
        n_fail++;
        conclude();
    end

    initial begin
        void'($urandom(32'h0DFA));
        repeat (3) @(negedge clock);
        arst_n = 1'b1;
        wait_ready();
        check_regs();
        $display("test power-up done");
        for (int i = 0; i < 8; i++) set_pll(2'(i), 1'($urandom));
        $display("test pll done");
        set_pll(2'b10, 1'b1);
        supply(1, 1'b0);
        supply(2, 1'b0);
        supply(3, 1'b1);
        supply(1, 1'b1);
        supply(2, 1'b1);
        supply(0, 1'b1);
        $display("test supply done");
        set_pll(2'b11, 1'b1);
        host.send(16'hFE00, 1'b0);
        @(negedge clock);
        chk("soft reset", 2'b01, {1'b0, internal_reset});
        chk("accept", 2'b00, {1'b0, cmd_accept});
        host.send(16'hD202, 1'b1);
        m_mode = 0;
        m_bw = 0;
        wait_ready();
        check_regs();
        $display("test soft reset done");
        set_pll(2'b01, 1'b1);
        arst_n = 1'b0;
        @(negedge clock);
        m_mode = 0;
        m_bw = 0;
        chk("async reset", 2'b01, {1'b0, internal_reset});
        check_regs();
        arst_n = 1'b1;
        wait_ready();
        check_regs();
        $display("test async reset done");
        conclude();
    end
endmodule : reset_mode_control_test
